// ==== hw/adcctl_pkg.sv ====
package adcctl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [6:0] REG_SPI_IDX  = 7'h01;
    localparam logic [6:0] REG_BUS_IDX  = 7'h02;
    localparam logic [6:0] REG_MODE_IDX = 7'h05;
    localparam logic [6:0] REG_STAT_IDX = 7'h10;
    localparam logic [6:0] REG_MASK_IDX = 7'h11;
    localparam int         ADDR_LSB     = 2;
    localparam int         REG_W        = 8;
    localparam int         SAMPLE_W     = 12;
    // Field positions
    localparam int BIT_FOUR_PIN   = 0;
    localparam int BIT_SINGLE_BUS = 0;
    localparam int BIT_EXT_REF    = 2;
    localparam int BIT_SYNC_EN    = 3;
    localparam int BIT_POWERDOWN  = 6;
    // Event bits of status and mask
    localparam int EV_REALIGN   = 0;
    localparam int EV_OVERRANGE = 1;
    localparam int EV_SERIAL    = 2;
    // Reset values
    localparam logic [7:0] RST_SPI  = 8'h00;
    localparam logic [7:0] RST_BUS  = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] EV_MASK  = 8'h07;
    // Serial frame: one command byte then one data byte
    localparam logic [2:0] SER_LAST_BIT = 3'h7;
    localparam int         SER_RW_BIT   = 7;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY    = 2'h0;

    typedef enum logic [2:0] {
        SP_IDLE, SP_CMD, SP_WDATA, SP_RDATA, SP_DONE
    } adcctl_sp_state_t;
endpackage : adcctl_pkg

// ==== hw/adcctl_top.sv ====
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/100ps
module adcctl_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic      [1:0]  hresp_o,
    output logic             irq_o,
    input  wire logic        single_bus_select_pin,
    input  wire logic        external_reference_select_pin,
    input  wire logic        powerdown_request_pin,
    output logic             single_bus_mode_o,
    output logic             ext_ref_mode_o,
    output logic             powerdown_o,
    input  wire logic        sample_valid_i,
    input  wire logic [11:0] sample_data_i,
    input  wire logic        sample_ovr_i,
    input  wire logic        clocked_realign_input,
    output logic      [11:0] bus_a_data_o,
    output logic      [11:0] bus_b_data_o,
    output logic             bus_a_overrange_out,
    output logic             bus_b_overrange_out,
    output logic             bus_a_data_ready_clock_out,
    output logic             bus_b_data_ready_clock_out,
    input  wire logic        serial_clock_i,
    input  wire logic        serial_select_n,
    input  wire logic        serial_data_i,
    output logic             serial_data_o,
    output logic             serial_data_oe_o,
    output logic             serial_readback_out,
    output logic             serial_readback_oe_o
);
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [7:0] spi_cfg_r;
    logic [7:0] bus_cfg_r;
    logic [7:0] mode_cfg_r;
    logic [7:0] stat_r;
    logic [7:0] mask_r;
    logic [7:0] stat_nxt;
    logic [7:0] ev;
    // Pin synchronisers: stage 1 is read only by stage 2
    logic [6:0] pin_s1_r;
    logic [6:0] pin_s2_r;
    logic       sclk_d_r;
    logic       wr_pend_r;
    logic [6:0] wr_idx_r;
    logic       ahb_wr;
    adcctl_pkg::adcctl_sp_state_t sp_state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] sin_r;
    logic [7:0] sout_r;
    logic [6:0] sp_addr_r;
    logic       sp_wr_r;
    logic [7:0] sp_wdata_r;
    logic       sp_done_r;
    logic       word_b_r;
    logic       ovr_ev_r;
    logic       realign_ev_r;
    logic       four_pin;
    logic       sync_en;
    logic       pwd_now;
    logic       single_now;

    wire sclk_s  = pin_s2_r[0];
    wire sel_n_s = pin_s2_r[1];
    wire sdin_s  = pin_s2_r[2];
    wire bus_pin = pin_s2_r[3];
    wire ref_pin = pin_s2_r[4];
    wire pwd_pin = pin_s2_r[5];
    wire pin_sync_realign = pin_s2_r[6];
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire sclk_fall = ~sclk_s & sclk_d_r;

    function automatic logic [7:0] reg_read(input logic [6:0] idx);
        case (idx)
            adcctl_pkg::REG_SPI_IDX:  reg_read = spi_cfg_r;
            adcctl_pkg::REG_BUS_IDX:  reg_read = bus_cfg_r;
            adcctl_pkg::REG_MODE_IDX: reg_read = mode_cfg_r;
            adcctl_pkg::REG_STAT_IDX: reg_read = stat_r;
            adcctl_pkg::REG_MASK_IDX: reg_read = mask_r;
            default:                  reg_read = 8'h00;
        endcase
    endfunction : reg_read

    assign four_pin   = spi_cfg_r[adcctl_pkg::BIT_FOUR_PIN];
    assign sync_en    = mode_cfg_r[adcctl_pkg::BIT_SYNC_EN];
    assign single_now = bus_pin | bus_cfg_r[adcctl_pkg::BIT_SINGLE_BUS];
    assign pwd_now    = pwd_pin | mode_cfg_r[adcctl_pkg::BIT_POWERDOWN];
    assign ahb_wr     = wr_pend_r & hready_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Select starts idle high so reset shows no false frame
            pin_s1_r <= 7'h02;
            pin_s2_r <= 7'h02;
            sclk_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {clocked_realign_input, powerdown_request_pin,
                         external_reference_select_pin,
                         single_bus_select_pin, serial_data_i,
                         serial_select_n, serial_clock_i};
            pin_s2_r <= pin_s1_r;
            sclk_d_r <= sclk_s;
        end
    end

    // Mode outputs track pins every cycle, no serial access needed
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            single_bus_mode_o <= 1'b0;
            ext_ref_mode_o    <= 1'b0;
            powerdown_o       <= 1'b0;
        end else begin
            single_bus_mode_o <= single_now;
            ext_ref_mode_o    <= ref_pin |
                mode_cfg_r[adcctl_pkg::BIT_EXT_REF];
            powerdown_o       <= pwd_now;
        end
    end

    // AHB-Lite slave, zero wait states
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_r   <= 1'b0;
            wr_idx_r    <= 7'h00;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= adcctl_pkg::HRESP_OKAY;
        end else if (hready_i) begin
            wr_pend_r <= hsel_i & htrans_i[1] & hwrite_i;
            wr_idx_r  <= haddr_i[adcctl_pkg::ADDR_LSB +: 7];
            if (hsel_i & htrans_i[1] & ~hwrite_i) begin
                hrdata_o <= {24'h00_0000,
                    reg_read(haddr_i[adcctl_pkg::ADDR_LSB +: 7])};
            end
        end
    end

    // Bus write wins over a serial write in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            spi_cfg_r  <= adcctl_pkg::RST_SPI;
            bus_cfg_r  <= adcctl_pkg::RST_BUS;
            mode_cfg_r <= adcctl_pkg::RST_MODE;
            mask_r     <= adcctl_pkg::RST_MASK;
        end else if (ahb_wr) begin
            case (wr_idx_r)
                adcctl_pkg::REG_SPI_IDX:  spi_cfg_r  <= hwdata_i[7:0];
                adcctl_pkg::REG_BUS_IDX:  bus_cfg_r  <= hwdata_i[7:0];
                adcctl_pkg::REG_MODE_IDX: mode_cfg_r <= hwdata_i[7:0];
                adcctl_pkg::REG_MASK_IDX:
                    mask_r <= hwdata_i[7:0] & adcctl_pkg::EV_MASK;
                default: ;
            endcase
        end else if (sp_wr_r) begin
            case (sp_addr_r)
                adcctl_pkg::REG_SPI_IDX:  spi_cfg_r  <= sp_wdata_r;
                adcctl_pkg::REG_BUS_IDX:  bus_cfg_r  <= sp_wdata_r;
                adcctl_pkg::REG_MODE_IDX: mode_cfg_r <= sp_wdata_r;
                default: ;
            endcase
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_comb begin
        ev = 8'h00;
        ev[adcctl_pkg::EV_REALIGN]   = realign_ev_r;
        ev[adcctl_pkg::EV_OVERRANGE] = ovr_ev_r;
        ev[adcctl_pkg::EV_SERIAL]    = sp_done_r;
        stat_nxt = stat_r;
        if (ahb_wr && wr_idx_r == adcctl_pkg::REG_STAT_IDX) begin
            stat_nxt = stat_r & ~hwdata_i[7:0];
        end
        stat_nxt = stat_nxt | ev;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_r <= adcctl_pkg::RST_STAT;
            irq_o  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_o  <= |(stat_r & mask_r);
        end
    end

    // Serial port on sampled serial clock edges
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sp_state_r <= adcctl_pkg::SP_IDLE;
            bit_cnt_r  <= 3'h0;
            sin_r      <= 8'h00;
            sout_r     <= 8'h00;
            sp_addr_r  <= 7'h00;
            sp_wr_r    <= 1'b0;
            sp_wdata_r <= 8'h00;
            sp_done_r  <= 1'b0;
        end else begin
            sp_wr_r   <= 1'b0;
            sp_done_r <= 1'b0;
            if (sel_n_s) begin
                sp_state_r <= adcctl_pkg::SP_IDLE;
                bit_cnt_r  <= 3'h0;
            end else begin
                case (sp_state_r)
                    adcctl_pkg::SP_IDLE: begin
                        sp_state_r <= adcctl_pkg::SP_CMD;
                        bit_cnt_r  <= 3'h0;
                    end
                    adcctl_pkg::SP_CMD: if (sclk_rise) begin
                        sin_r     <= {sin_r[6:0], sdin_s};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == adcctl_pkg::SER_LAST_BIT) begin
                            sp_addr_r <= {sin_r[5:0], sdin_s};
                            sout_r    <= reg_read({sin_r[5:0], sdin_s});
                            sp_state_r <= sin_r[adcctl_pkg::SER_RW_BIT - 1]
                                ? adcctl_pkg::SP_RDATA
                                : adcctl_pkg::SP_WDATA;
                        end
                    end
                    adcctl_pkg::SP_WDATA: if (sclk_rise) begin
                        sin_r     <= {sin_r[6:0], sdin_s};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == adcctl_pkg::SER_LAST_BIT) begin
                            sp_wdata_r <= {sin_r[6:0], sdin_s};
                            sp_wr_r    <= 1'b1;
                            sp_done_r  <= 1'b1;
                            sp_state_r <= adcctl_pkg::SP_DONE;
                        end
                    end
                    adcctl_pkg::SP_RDATA: if (sclk_fall) begin
                        sout_r    <= {sout_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == adcctl_pkg::SER_LAST_BIT) begin
                            sp_done_r  <= 1'b1;
                            sp_state_r <= adcctl_pkg::SP_DONE;
                        end
                    end
                    adcctl_pkg::SP_DONE: ;
                    default: sp_state_r <= adcctl_pkg::SP_IDLE;
                endcase
            end
        end
    end

    // Pin drivers; drive only while reading with select still low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_data_o        <= 1'b0;
            serial_data_oe_o     <= 1'b0;
            serial_readback_out  <= 1'b0;
            serial_readback_oe_o <= 1'b0;
        end else begin
            serial_data_o        <= sout_r[7];
            serial_readback_out  <= sout_r[7];
            serial_data_oe_o     <= ~four_pin & ~sel_n_s &
                (sp_state_r == adcctl_pkg::SP_RDATA);
            serial_readback_oe_o <= four_pin & ~sel_n_s &
                (sp_state_r == adcctl_pkg::SP_RDATA);
        end
    end

    // Output buses; realign restarts the phase at bus A, clock high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_b_r                   <= 1'b0;
            bus_a_data_o               <= 12'h000;
            bus_b_data_o               <= 12'h000;
            bus_a_overrange_out        <= 1'b0;
            bus_b_overrange_out        <= 1'b0;
            bus_a_data_ready_clock_out <= 1'b0;
            bus_b_data_ready_clock_out <= 1'b0;
            ovr_ev_r                   <= 1'b0;
            realign_ev_r               <= 1'b0;
        end else begin
            ovr_ev_r     <= 1'b0;
            realign_ev_r <= 1'b0;
            // Sleep drops samples and freezes the buses
            if (sample_valid_i && !pwd_now) begin
                ovr_ev_r <= sample_ovr_i & ~sync_en;
                if (pin_sync_realign) begin
                    realign_ev_r               <= 1'b1;
                    word_b_r                   <= ~single_now;
                    bus_a_data_o               <= sample_data_i;
                    bus_a_data_ready_clock_out <= 1'b1;
                    bus_b_data_ready_clock_out <= 1'b0;
                    bus_a_overrange_out <= sync_en | sample_ovr_i;
                    if (sync_en) begin
                        bus_b_overrange_out <= 1'b0;
                    end
                end else if (single_now || !word_b_r) begin
                    word_b_r                   <= ~single_now;
                    bus_a_data_o               <= sample_data_i;
                    bus_a_data_ready_clock_out <=
                        ~bus_a_data_ready_clock_out;
                    bus_a_overrange_out <= ~sync_en & sample_ovr_i;
                end else begin
                    word_b_r                   <= 1'b0;
                    bus_b_data_o               <= sample_data_i;
                    bus_b_data_ready_clock_out <=
                        ~bus_b_data_ready_clock_out;
                    bus_b_overrange_out <= ~sync_en & sample_ovr_i;
                end
            end
        end
    end

    chk_single_bus_or: assert property (
        single_bus_mode_o == $past(single_now))
        else $error("single bus mode is not pin OR bit");
    chk_ext_ref_or: assert property (
        ext_ref_mode_o == $past(ref_pin |
        mode_cfg_r[adcctl_pkg::BIT_EXT_REF]))
        else $error("external reference is not pin OR bit");
    chk_powerdown_or: assert property (
        pwd_pin |=> powerdown_o)
        else $error("power-down missed its pin");
    chk_irq_level: assert property (
        irq_o == $past(|(stat_r & mask_r)))
        else $error("interrupt does not follow unmasked status");
    chk_sdo_hiz: assert property (
        !four_pin |=> !serial_readback_oe_o)
        else $error("readback pin driven in 3-pin mode");
    chk_sdio_in_only: assert property (
        four_pin |=> !serial_data_oe_o)
        else $error("data pin driven in 4-pin mode");
    chk_sel_abort: assert property (
        sel_n_s |=> sp_state_r == adcctl_pkg::SP_IDLE ##1
        !serial_data_oe_o && !serial_readback_oe_o)
        else $error("transfer not abandoned on select high");
    chk_realign_pol: assert property (
        sample_valid_i && !pwd_now && pin_sync_realign |=>
        bus_a_data_ready_clock_out && !bus_b_data_ready_clock_out)
        else $error("realign did not reset clock polarity");
    chk_sync_mark: assert property (
        sample_valid_i && !pwd_now && pin_sync_realign && sync_en |=>
        bus_a_overrange_out)
        else $error("sync marker missing on realigned word");
    chk_bus_toggle: assert property (
        sample_valid_i && !pwd_now && !pin_sync_realign && single_now |=>
        $changed(bus_a_data_ready_clock_out))
        else $error("bus A clock did not toggle with word");
endmodule : adcctl_top

// ==== test/adcctl_ser_host.sv ====
`timescale 1ns/100ps
module adcctl_ser_host (
    input  wire logic sd_i,
    input  wire logic sd_oe_i,
    input  wire logic ro_i,
    input  wire logic ro_oe_i,
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      sdio_o,
    output logic      oe_seen_o,
    output logic      ro_seen_o
);
    logic drv_en, drv_d, last_v;

    initial begin
        sclk_o    = 1'b0;
        sel_n_o   = 1'b1;
        drv_en    = 1'b0;
        drv_d     = 1'b0;
        last_v    = 1'b0;
        oe_seen_o = 1'b0;
        ro_seen_o = 1'b0;
    end
    // Undriven pin shows the inverse of its last level, never a stale copy
    always_comb sdio_o = sd_oe_i ? sd_i : (drv_en ? drv_d : ~last_v);
    always @(sd_oe_i, sd_i, drv_en, drv_d)
        if (sd_oe_i | drv_en) last_v = sd_oe_i ? sd_i : drv_d;
    always @(posedge sd_oe_i) oe_seen_o = 1'b1;
    always @(posedge ro_oe_i) ro_seen_o = 1'b1;

    // Clock stands low outside frames
    task automatic xfer(input logic [15:0] bits, input int n,
                        input logic four, output logic [7:0] rd);
        int i;
        // Keep every pin change off the block's clock edges
        #1;
        rd        = 8'h00;
        oe_seen_o = 1'b0;
        ro_seen_o = 1'b0;
        sel_n_o   = 1'b0;
        for (i = 0; i < n; i++) begin
            drv_en = (i < 8) | ~bits[15];
            drv_d  = bits[15 - i];
            #40 sclk_o = 1'b1;
            // Let go once the last command bit is taken, before the answer
            #10;
            if (i == 7 && bits[15]) drv_en = 1'b0;
            #30;
            // Readback moves after each falling edge: take it just before
            if (i >= 7 && i < 15)
                rd[14 - i] = four ? (ro_oe_i ? ro_i : ~ro_i) : sdio_o;
            sclk_o = 1'b0;
        end
        drv_en = 1'b0;
        #40 sel_n_o = 1'b1;
        #80;
    endtask : xfer
endmodule : adcctl_ser_host

// ==== test/test_adcctl_top.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, a) begin \
    checks_done++; \
    if ((a) !== (e)) begin \
        miscompares++; \
        $display("unexpected %s exp %h got %h", nm, e, a); \
    end \
end
module test_adcctl_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hsel_i = 1'b0, hwrite_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, r, rv;
    logic [1:0]  htrans_i = 2'h0, hresp_o;
    logic [2:0]  hsize_i = 3'h2, pins = 3'h0;
    logic        valid = 1'b0, sovr = 1'b0, realign = 1'b0;
    logic [11:0] sdata = 12'h000, bus_a, bus_b;
    logic        hreadyout_o, irq_o, sb_o, er_o, pd_o, ova, ovb, cka, ckb;
    logic        sclk, seln, sdio, sd_o, sd_oe, ro, ro_oe, oe_sn, ro_sn;
    logic [7:0]  mreg [0:127] = '{default: 8'h00};
    logic [7:0]  rb;
    logic [6:0]  idxs [5] = '{7'h01, 7'h02, 7'h05, 7'h10, 7'h11};
    logic        ca = 1'b0, cb = 1'b0, nb = 1'b0;
    int          seed = 4, miscompares = 0, checks_done = 0, i;

    adcctl_top dut (
        .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
        .hresp_o, .irq_o,
        .single_bus_select_pin(pins[0]),
        .external_reference_select_pin(pins[1]),
        .powerdown_request_pin(pins[2]),
        .single_bus_mode_o(sb_o), .ext_ref_mode_o(er_o), .powerdown_o(pd_o),
        .sample_valid_i(valid), .sample_data_i(sdata), .sample_ovr_i(sovr),
        .clocked_realign_input(realign),
        .bus_a_data_o(bus_a), .bus_b_data_o(bus_b),
        .bus_a_overrange_out(ova), .bus_b_overrange_out(ovb),
        .bus_a_data_ready_clock_out(cka), .bus_b_data_ready_clock_out(ckb),
        .serial_clock_i(sclk), .serial_select_n(seln), .serial_data_i(sdio),
        .serial_data_o(sd_o), .serial_data_oe_o(sd_oe),
        .serial_readback_out(ro), .serial_readback_oe_o(ro_oe)
    );
    adcctl_ser_host host (
        .sd_i(sd_o), .sd_oe_i(sd_oe), .ro_i(ro), .ro_oe_i(ro_oe),
        .sclk_o(sclk), .sel_n_o(seln), .sdio_o(sdio),
        .oe_seen_o(oe_sn), .ro_seen_o(ro_sn)
    );

    always #2.5 clk_i = ~clk_i;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // Zero wait states are expected but never assumed
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 20);
        if (hreadyout_o !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [6:0] idx,
                       input logic [7:0] wd);
        @(posedge clk_i);
        hsel_i   <= 1'b1;
        htrans_i <= adcctl_pkg::HTRANS_NONSEQ;
        haddr_i  <= {23'h000000, idx, 2'h0};
        hwrite_i <= wr;
        wait_rdy();
        htrans_i <= 2'h0;
        hwdata_i <= {24'h000000, wd};
        wait_rdy();
        r = hrdata_o;
        `CHK("response", adcctl_pkg::HRESP_OKAY, hresp_o)
    endtask : ahb

    task automatic wreg(input logic [6:0] idx, input logic [7:0] d);
        ahb(1'b1, idx, d);
        if (idx == adcctl_pkg::REG_STAT_IDX)
            mreg[idx] = mreg[idx] & ~d;
        else if (idx != 7'h03)
            mreg[idx] = d;
    endtask : wreg

    task automatic rdchk(input logic [6:0] idx);
        ahb(1'b0, idx, 8'h00);
        `CHK("register", {24'h000000, mreg[idx]}, r)
    endtask : rdchk

    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    // One converter word; realign held long enough to pass the synchroniser
    task automatic word(input logic rl, input logic ov);
        logic [11:0] d;
        logic        a;
        d = 12'($random(seed));
        @(posedge clk_i);
        realign <= rl;
        repeat (3) @(posedge clk_i);
        valid <= 1'b1;
        sdata <= d;
        sovr  <= ov;
        @(posedge clk_i);
        valid   <= 1'b0;
        realign <= 1'b0;
        a = rl | mreg[2][0] | ~nb;
        if (rl) begin
            ca = 1'b1;
            cb = 1'b0;
        end else if (a)
            ca = ~ca;
        else
            cb = ~cb;
        nb = a & ~mreg[2][0];
        #1;
        `CHK("bus word", d, a ? bus_a : bus_b)
        `CHK("ready clocks", {ca, cb}, {cka, ckb})
        `CHK("overrange", mreg[5][3] ? rl : ov, a ? ova : ovb)
        repeat (3) @(posedge clk_i);
    endtask : word

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (idxs[k]) rdchk(idxs[k]);
        wreg(7'h03, 8'hff);
        rdchk(7'h03);
        $display("register reset test done");
        for (i = 0; i < 12; i++) begin
            rv = $random(seed);
            wreg(7'h02, {7'h00, rv[3]});
            wreg(7'h05, {1'b0, rv[6], 3'h0, rv[2], 2'h0});
            @(posedge clk_i);
            pins <= rv[10:8];
            repeat (6) @(posedge clk_i);
            #1;
            `CHK("single bus", pins[0] | mreg[2][0], sb_o)
            `CHK("ext ref", pins[1] | mreg[5][2], er_o)
            `CHK("power down", pins[2] | mreg[5][6], pd_o)
        end
        @(posedge clk_i);
        pins <= 3'h0;
        wreg(7'h02, 8'h00);
        wreg(7'h05, 8'h00);
        $display("mode pin test done");
        for (i = 0; i < 24; i++) begin
            if (i == 8) wreg(7'h02, 8'h01);
            if (i == 13) wreg(7'h02, 8'h00);
            if (i == 16) wreg(7'h05, 8'h08);
            word(i % 5 == 3, 1'($random(seed)));
        end
        $display("data path test done");
        wreg(7'h11, 8'h01);
        wreg(7'h10, 8'h07);
        rdchk(7'h10);
        `CHK("irq idle", 1'b0, irq_o)
        word(1'b1, 1'b0);
        mreg[7'h10] = 8'h01;
        `CHK("irq raised", 1'b1, irq_o)
        rdchk(7'h10);
        wreg(7'h11, 8'h00);
        settle();
        `CHK("irq masked", 1'b0, irq_o)
        wreg(7'h11, 8'h01);
        settle();
        `CHK("irq unmasked", 1'b1, irq_o)
        wreg(7'h10, 8'h01);
        settle();
        `CHK("irq cleared", 1'b0, irq_o)
        rdchk(7'h10);
        $display("interrupt test done");
        host.xfer({1'b0, 7'h02, 8'h01}, 16, 1'b0, rb);
        mreg[2] = 8'h01;
        rdchk(7'h02);
        host.xfer({1'b1, 7'h05, 8'h00}, 16, 1'b0, rb);
        `CHK("readback 3pin", mreg[5], rb)
        `CHK("shared pin driven", 1'b1, oe_sn)
        `CHK("readback pin idle", 1'b0, ro_sn)
        host.xfer({1'b0, 7'h02, 8'h00}, 12, 1'b0, rb);
        rdchk(7'h02);
        wreg(7'h01, 8'h01);
        host.xfer({1'b1, 7'h02, 8'h00}, 16, 1'b1, rb);
        `CHK("readback 4pin", mreg[2], rb)
        `CHK("data pin input", 1'b0, oe_sn)
        `CHK("readback pin driven", 1'b1, ro_sn)
        host.xfer({1'b0, 7'h02, 8'h00}, 16, 1'b1, rb);
        mreg[2] = 8'h00;
        rdchk(7'h02);
        $display("serial port test done");
        end_of_test();
    end
endmodule : test_adcctl_top
